// ---- verilog/pmtr_regs.vh ----
// constants for the program memory table read block
`ifndef PMTR_REGS_VH
`define PMTR_REGS_VH
`define PMTR_RESET_VECTOR   11'h000
`define PMTR_LAST_PAGE_BASE 11'h700
`define PMTR_PAGE_HIGH_MSB  10
`define PMTR_PAGE_HIGH_LSB  8
`define PMTR_PHASES         2'h3
`define PMTR_HIGH_RESET     8'h00
`define PMTR_OP_ADD   5'h00
`define PMTR_OP_ADC   5'h01
`define PMTR_OP_SUB   5'h02
`define PMTR_OP_SBC   5'h03
`define PMTR_OP_DECADJ 5'h04
`define PMTR_OP_AND   5'h05
`define PMTR_OP_OR    5'h06
`define PMTR_OP_XOR   5'h07
`define PMTR_OP_CPL   5'h08
`define PMTR_OP_RR    5'h09
`define PMTR_OP_RRC   5'h0A
`define PMTR_OP_RL    5'h0B
`define PMTR_OP_RLC   5'h0C
`define PMTR_OP_INC   5'h0D
`define PMTR_OP_DEC   5'h0E
`define PMTR_OP_SZ    5'h0F
`define PMTR_OP_SNZ   5'h10
`define PMTR_OP_SIZ   5'h11
`define PMTR_OP_SDZ   5'h12
`define PMTR_OP_JMP   5'h13
`define PMTR_OP_TRDC  5'h14
`define PMTR_OP_TRDL  5'h15
`define PMTR_OP_NOP   5'h1F
`endif

// ---- verilog/pmtr_core.v ----
// program memory, alu, table read and serial programming pins
//
// Behaviour
// - alu writes result, updates carry and flags
// - add, sub, adjust, logic, rotate, inc, skip
// - program memory holds 2K sixteen-bit words
// - reset loads program counter with 000H
// - table pointer supplies table read address
// - table read low byte goes to register
// - high byte to table_high_byte, unused zero
// - last page read address is 700H+pointer
// - table_high_byte changed only by table reads
// - table instructions take two instruction cycles
// - serial data pin plus clock pin programming
// - debug data bidirectional, clock input, sharing off
// - debug pins double as programming pins
// - four phases per instruction cycle, fetch first
// - page spans 256 words, 8-bit low address
`timescale 1ns/1ps
`include "pmtr_regs.vh"
module pmtr_core #(
	parameter ADDR_W = 11,
	parameter WORD_W = 16,
	parameter HIGH_W = 8
) (
	// clock and reset
	input  wire                clk,
	input  wire                rst,
	// instruction from pipeline, taken at phase 0; tablePointer latched at phase 3
	input  wire                instValid,
	input  wire [4:0]          instOp,
	input  wire [7:0]          instOperand,
	input  wire [7:0]          instDest,
	input  wire [ADDR_W-1:0]   instTarget,
	input  wire [7:0]          tablePointer,
	// data memory write port
	output reg                 dataWrEn,
	output reg  [7:0]          dataWrAddr,
	output reg  [7:0]          dataWrData,
	// status and control
	output reg                 carryFlag,
	output reg                 zeroFlag,
	output reg                 auxCarryFlag,
	output reg                 overflowFlag,
	output reg                 skipNext,
	output reg  [ADDR_W-1:0]   progCounter,
	output reg  [HIGH_W-1:0]   tableHighByte,
	output reg  [1:0]          phase,
	output reg                 busy,
	// serial pins: debug mode and shared port function
	input  wire                debugMode,
	input  wire                portOut,
	input  wire                portOutEnN,
	output reg                 portIn,
	input  wire                progSerialDataIn,
	input  wire                progSerialClockIn,
	output reg                 progSerialDataOut,
	output reg                 progSerialDataOeN,
	// programmer word port
	output reg                 progWordValid,
	output reg  [WORD_W-1:0]   progWordData
);
	localparam ST_FETCH = 2'h0;
	localparam ST_EXEC  = 2'h1;
	localparam ST_TABLE = 2'h2;

	reg [WORD_W-1:0] progMem [0:(1<<ADDR_W)-1];
	reg [1:0]        state_reg;
	reg [4:0]        op_reg;
	reg [7:0]        operand_reg;
	reg [7:0]        dest_reg;
	reg [ADDR_W-1:0] target_reg;
	reg [ADDR_W-1:0] tableAddr_reg;
	reg [WORD_W-1:0] tableWord_reg;
	reg              dataSync1, dataSync2, clkSync1, clkSync2, clkPrev;
	reg [4:0]        bitCount_reg;
	reg [WORD_W-1:0] shift_reg;
	reg [ADDR_W-1:0] progAddr_reg;
	reg              serialReadback;

	// alu combinational result
	reg [8:0] sum;
	reg [7:0] res;
	reg       cOut, acOut, ovOut, zSkip, writes;
	reg [8:0] adjTmp;
	always @* begin
		sum    = 9'h000;
		res    = 8'h00;
		cOut   = carryFlag;
		acOut  = auxCarryFlag;
		ovOut  = overflowFlag;
		zSkip  = 1'b0;
		writes = 1'b1;
		adjTmp = 9'h000;
		case (op_reg)
		`PMTR_OP_ADD, `PMTR_OP_ADC: begin
			sum   = {1'b0, operand_reg} + {1'b0, dest_reg}
				+ {8'h00, (op_reg == `PMTR_OP_ADC) & carryFlag};
			res   = sum[7:0];
			cOut  = sum[8];
			acOut = (operand_reg[3:0] + dest_reg[3:0]) > 5'h0F;
			ovOut = (operand_reg[7] == dest_reg[7]) && (res[7] != dest_reg[7]);
		end
		`PMTR_OP_SUB, `PMTR_OP_SBC: begin
			sum   = {1'b0, dest_reg} + {1'b0, ~operand_reg}
				+ {8'h00, (op_reg == `PMTR_OP_SUB) | carryFlag};
			res   = sum[7:0];
			cOut  = sum[8];
			acOut = dest_reg[3:0] >= operand_reg[3:0];
			ovOut = (operand_reg[7] != dest_reg[7]) && (res[7] != dest_reg[7]);
		end
		`PMTR_OP_DECADJ: begin
			adjTmp = {1'b0, dest_reg};
			if (auxCarryFlag || adjTmp[3:0] > 4'h9)
				adjTmp = adjTmp + 9'h006;
			if (carryFlag || adjTmp[8] || adjTmp[7:4] > 4'h9)
				adjTmp = adjTmp + 9'h060;
			res  = adjTmp[7:0];
			cOut = carryFlag | adjTmp[8];
		end
		`PMTR_OP_AND: res = dest_reg & operand_reg;
		`PMTR_OP_OR:  res = dest_reg | operand_reg;
		`PMTR_OP_XOR: res = dest_reg ^ operand_reg;
		`PMTR_OP_CPL: res = ~dest_reg;
		`PMTR_OP_RR:  res = {dest_reg[0], dest_reg[7:1]};
		`PMTR_OP_RL:  res = {dest_reg[6:0], dest_reg[7]};
		`PMTR_OP_RRC: begin
			res  = {carryFlag, dest_reg[7:1]};
			cOut = dest_reg[0];
		end
		`PMTR_OP_RLC: begin
			res  = {dest_reg[6:0], carryFlag};
			cOut = dest_reg[7];
		end
		`PMTR_OP_INC, `PMTR_OP_SIZ: begin
			res   = dest_reg + 8'h01;
			zSkip = (op_reg == `PMTR_OP_SIZ) && (res == 8'h00);
		end
		`PMTR_OP_DEC, `PMTR_OP_SDZ: begin
			res   = dest_reg - 8'h01;
			zSkip = (op_reg == `PMTR_OP_SDZ) && (res == 8'h00);
		end
		`PMTR_OP_SZ: begin
			writes = 1'b0;
			zSkip  = dest_reg == 8'h00;
		end
		`PMTR_OP_SNZ: begin
			writes = 1'b0;
			zSkip  = dest_reg != 8'h00;
		end
		default: writes = 1'b0;
		endcase
	end

	wire isTable = (op_reg == `PMTR_OP_TRDC) || (op_reg == `PMTR_OP_TRDL);
	wire isSkipOnly = (op_reg == `PMTR_OP_SZ) || (op_reg == `PMTR_OP_SNZ);
	wire [ADDR_W-1:0] pageAddr = {progCounter[`PMTR_PAGE_HIGH_MSB:`PMTR_PAGE_HIGH_LSB],
		tablePointer};
	wire [ADDR_W-1:0] lastAddr = `PMTR_LAST_PAGE_BASE + {3'h0, tablePointer};

	// instruction sequencer
	always @(posedge clk) begin
		dataWrEn <= 1'b0;
		if (rst) begin
			progCounter   <= `PMTR_RESET_VECTOR;
			phase         <= 2'h0;
			state_reg     <= ST_FETCH;
			busy          <= 1'b0;
			carryFlag     <= 1'b0;
			zeroFlag      <= 1'b0;
			auxCarryFlag  <= 1'b0;
			overflowFlag  <= 1'b0;
			skipNext      <= 1'b0;
			tableHighByte <= `PMTR_HIGH_RESET;
			op_reg        <= `PMTR_OP_NOP;
			operand_reg   <= 8'h00;
			dest_reg      <= 8'h00;
			target_reg    <= {ADDR_W{1'b0}};
			tableAddr_reg <= {ADDR_W{1'b0}};
			tableWord_reg <= {WORD_W{1'b0}};
			dataWrAddr    <= 8'h00;
			dataWrData    <= 8'h00;
		end else begin
			phase <= phase + 2'h1;
			case (state_reg)
			ST_FETCH: if (phase == 2'h0) begin
				progCounter <= progCounter + {{(ADDR_W-1){1'b0}}, 1'b1};
				if (instValid) begin
					op_reg      <= instOp;
					operand_reg <= instOperand;
					dest_reg    <= instDest;
					target_reg  <= instTarget;
					busy        <= 1'b1;
					state_reg   <= ST_EXEC;
				end
			end
			ST_EXEC: if (phase == `PMTR_PHASES) begin
				if (isTable) begin
					tableAddr_reg <= (op_reg == `PMTR_OP_TRDL) ? lastAddr : pageAddr;
					state_reg     <= ST_TABLE;
				end else begin
					if (op_reg == `PMTR_OP_JMP)
						progCounter <= target_reg;
					if (writes) begin
						dataWrEn     <= 1'b1;
						dataWrAddr   <= dest_reg;
						dataWrData   <= res;
						zeroFlag     <= res == 8'h00;
						carryFlag    <= cOut;
						auxCarryFlag <= acOut;
						overflowFlag <= ovOut;
					end
					skipNext  <= zSkip | (isSkipOnly & zSkip);
					busy      <= 1'b0;
					state_reg <= ST_FETCH;
				end
			end else if (phase == 2'h1 && isTable) begin
				tableWord_reg <= progMem[(op_reg == `PMTR_OP_TRDL) ? lastAddr : pageAddr];
			end
			// second instruction cycle: fetch the word, then write both halves
			ST_TABLE: if (phase == 2'h1) begin
				tableWord_reg <= progMem[tableAddr_reg];
			end else if (phase == `PMTR_PHASES) begin
				dataWrEn      <= 1'b1;
				dataWrAddr    <= operand_reg;
				dataWrData    <= tableWord_reg[7:0];
				tableHighByte <= tableWord_reg[WORD_W-1:8];
				busy          <= 1'b0;
				state_reg     <= ST_FETCH;
			end
			default: state_reg <= ST_FETCH;
			endcase
		end
	end

	// serial programming and debug pins, shared with a port function
	always @(posedge clk) begin
		progWordValid <= 1'b0;
		if (rst) begin
			dataSync1         <= 1'b0;
			dataSync2         <= 1'b0;
			clkSync1          <= 1'b0;
			clkSync2          <= 1'b0;
			clkPrev           <= 1'b0;
			bitCount_reg      <= 5'h00;
			shift_reg         <= {WORD_W{1'b0}};
			progAddr_reg      <= {ADDR_W{1'b0}};
			serialReadback    <= 1'b0;
			progSerialDataOut <= 1'b0;
			progSerialDataOeN <= 1'b1;
			portIn            <= 1'b0;
			progWordData      <= {WORD_W{1'b0}};
		end else begin
			dataSync1 <= progSerialDataIn;
			dataSync2 <= dataSync1;
			clkSync1  <= progSerialClockIn;
			clkSync2  <= clkSync1;
			clkPrev   <= clkSync2;
			if (debugMode) begin
				portIn            <= 1'b0;
				progSerialDataOeN <= ~serialReadback;
				progSerialDataOut <= shift_reg[0];
				if (clkSync2 && !clkPrev) begin
					if (serialReadback) begin
						shift_reg <= {1'b0, shift_reg[WORD_W-1:1]};
						if (bitCount_reg == 5'h0F) begin
							serialReadback <= 1'b0;
							bitCount_reg   <= 5'h00;
						end else
							bitCount_reg <= bitCount_reg + 5'h01;
					end else begin
						shift_reg <= {dataSync2, shift_reg[WORD_W-1:1]};
						if (bitCount_reg == 5'h0F) begin
							bitCount_reg   <= 5'h00;
							progWordValid  <= 1'b1;
							progWordData   <= {dataSync2, shift_reg[WORD_W-1:1]};
							progAddr_reg   <= progAddr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
							serialReadback <= 1'b1;
						end else
							bitCount_reg <= bitCount_reg + 5'h01;
					end
				end
			end else begin
				portIn            <= dataSync2;
				progSerialDataOut <= portOut;
				progSerialDataOeN <= portOutEnN;
				bitCount_reg      <= 5'h00;
				serialReadback    <= 1'b0;
				progAddr_reg      <= {ADDR_W{1'b0}};
			end
		end
	end

	// programmer writes words into program memory
	always @(posedge clk) begin
		if (progWordValid)
			progMem[progAddr_reg - {{(ADDR_W-1){1'b0}}, 1'b1}] <= progWordData;
	end
endmodule // pmtr_core

// ---- tb/pmtr_core_chk.sv ----
// port assertions for the program memory table read core
`timescale 1ns/1ps
`include "pmtr_regs.vh"
module pmtr_core_chk (
	// clock and reset
	input wire        clk,
	input wire        rst,
	// instruction side
	input wire        instValid,
	input wire [4:0]  instOp,
	input wire [7:0]  instOperand,
	input wire [7:0]  instDest,
	input wire [1:0]  phase,
	input wire        busy,
	// results
	input wire        dataWrEn,
	input wire [7:0]  dataWrAddr,
	input wire [10:0] progCounter,
	input wire [7:0]  tableHighByte,
	// pins
	input wire        debugMode,
	input wire        portIn,
	input wire        progWordValid
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	wire take  = instValid && !busy && phase == 2'h0;
	wire isTbl = instOp == `PMTR_OP_TRDC || instOp == `PMTR_OP_TRDL;
	wire isAlu = instOp <= `PMTR_OP_DEC;
	chk_reset_vector: assert property (disable iff (1'b0) rst |=> progCounter == 11'h000)
		else $error("pc not at reset vector");
	chk_phase_wrap: assert property (phase == 2'h3 |=> phase == 2'h0 ##1 phase == 2'h1)
		else $error("phase sequence broken");
	chk_alu_latency: assert property (take && isAlu |=> busy [*3] ##1 (dataWrEn && !busy))
		else $error("alu op timing wrong");
	chk_table_latency: assert property (take && isTbl |=> busy [*7] ##1 (dataWrEn && !busy))
		else $error("table read timing wrong");
	chk_alu_dest: assert property (take && isAlu |-> ##4 dataWrAddr == $past(instDest, 4))
		else $error("alu write address wrong");
	chk_table_dest: assert property (take && isTbl |-> ##8 dataWrAddr == $past(instOperand, 8))
		else $error("table write address wrong");
	chk_high_only_table: assert property (!$stable(tableHighByte) |-> $past(take && isTbl, 8))
		else $error("high byte changed without table read");
	chk_debug_port_quiet: assert property (debugMode && $past(debugMode, 2) |-> !portIn)
		else $error("port input active in debug mode");
	chk_word_pulse: assert property (progWordValid |=> !progWordValid)
		else $error("word strobe longer than one cycle");
endmodule // pmtr_core_chk
bind pmtr_core pmtr_core_chk chk (.clk, .rst, .instValid, .instOp, .instOperand, .instDest,
	.phase, .busy, .dataWrEn, .dataWrAddr, .progCounter, .tableHighByte, .debugMode, .portIn,
	.progWordValid);

// ---- tb/pmtr_prog_model.sv ----
// serial programmer on the shared data and clock pins
`timescale 1ns/1ps
module pmtr_prog_model (
	// clock
	input wire clk,
	// pins
	input wire sdOut,
	output reg sdDrv,
	output reg sck
);
	initial begin
		sdDrv = 1'b0;
		sck = 1'b0;
	end
	task automatic half;
		repeat (4) @(posedge clk);
	endtask
	// one word lsb first, then sixteen clocks of readback
	task automatic send_word(input [15:0] w, output [15:0] back);
		integer i;
		for (i = 0; i < 32; i = i + 1) begin
			if (i < 16)
				sdDrv <= w[i];
			else if (i == 16)
				sdDrv <= ~w[15];
			half;
			if (i >= 16)
				back[i-16] = sdOut;
			sck <= 1'b1;
			half;
			sck <= 1'b0;
		end
		sdDrv <= ~sdDrv;
	endtask
endmodule // pmtr_prog_model

// ---- tb/pmtr_core_bench.sv ----
// self-checking bench for the program memory table read core
`timescale 1ns/1ps
`include "pmtr_regs.vh"
module pmtr_core_bench;
	reg         clk, rst, instValid, debugMode;
	reg  [4:0]  instOp;
	reg  [7:0]  instOperand, instDest, tablePointer;
	reg  [15:0] lastWord;
	wire        dataWrEn, carryFlag, zeroFlag, busy, portIn, progWordValid;
	wire        auxCarryFlag, overflowFlag, skipNext;
	wire        progSerialDataOut, progSerialDataOeN, modelDrv, sck, progSerialDataIn;
	wire [7:0]  dataWrAddr, dataWrData, tableHighByte;
	wire [10:0] progCounter;
	wire [1:0]  phase;
	wire [15:0] progWordData;
	integer     err_total, checks_done;
	assign progSerialDataIn = progSerialDataOeN ? modelDrv : progSerialDataOut;
	pmtr_core dut (.clk, .rst, .instValid, .instOp, .instOperand, .instDest,
		.instTarget(11'h000), .tablePointer, .dataWrEn, .dataWrAddr, .dataWrData,
		.carryFlag, .zeroFlag, .auxCarryFlag, .overflowFlag, .skipNext,
		.progCounter, .tableHighByte, .phase, .busy, .debugMode, .portOut(1'b0),
		.portOutEnN(1'b1), .portIn, .progSerialDataIn, .progSerialClockIn(sck),
		.progSerialDataOut, .progSerialDataOeN, .progWordValid, .progWordData);
	pmtr_prog_model prog (.clk, .sdOut(progSerialDataOut), .sdDrv(modelDrv), .sck);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (progWordValid)
			lastWord <= progWordData;
	end
	task automatic check(input string nm, input [15:0] seen, input [15:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		#1;
		check("pc", progCounter, 11'h000);
		check("high byte", tableHighByte, 8'h00);
		@(posedge clk);
		rst <= 1'b0;
		#1;
		$display("reset test done");
	endtask
	task automatic issue(input [4:0] op, input [7:0] opd, dst, ptr, input integer n);
		integer k;
		for (k = 0; k < 12 && (phase !== 2'h3 || busy !== 1'b0); k = k + 1) begin
			@(posedge clk);
			#1;
		end
		if (k == 12) begin
			err_total = err_total + 1;
			$display("Error idle wait expected 0 seen 1");
		end
		@(posedge clk);
		instOp <= op;
		instOperand <= opd;
		instDest <= dst;
		tablePointer <= ptr;
		instValid <= 1'b1;
		@(posedge clk);
		instValid <= 1'b0;
		repeat (n - 2) @(posedge clk);
		#1;
		check("busy", busy, 1'b1);
		@(posedge clk);
		#1;
		check("write strobe", dataWrEn, 1'b1);
	endtask
	task automatic alu(input [4:0] op, input [7:0] opd, dst, res);
		reg [7:0] high;
		high = tableHighByte;
		issue(op, opd, dst, 8'h00, 4);
		check("alu result", dataWrData, res);
		check("alu dest", dataWrAddr, dst);
		check("high kept", tableHighByte, high);
	endtask
	task automatic t_prog;
		reg [15:0] k, back;
		@(posedge clk);
		debugMode <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check("port in", portIn, 1'b0);
		for (k = 0; k < 4; k = k + 1) begin
			prog.send_word(16'hA50F ^ (16'h1111 * k), back);
			#1;
			check("word", lastWord, 16'hA50F ^ (16'h1111 * k));
			check("readback", back, 16'hA50F ^ (16'h1111 * k));
		end
		@(posedge clk);
		debugMode <= 1'b0;
		#1;
		$display("programming test done");
	endtask
	task automatic t_alu;
		alu(`PMTR_OP_ADD, 8'h20, 8'hF0, 8'h10);
		check("carry", carryFlag, 1'b1);
		alu(`PMTR_OP_ADC, 8'h01, 8'h01, 8'h03);
		check("carry clear", carryFlag, 1'b0);
		alu(`PMTR_OP_ADD, 8'h40, 8'h40, 8'h80);
		check("overflow", overflowFlag, 1'b1);
		alu(`PMTR_OP_ADD, 8'h08, 8'h08, 8'h10);
		check("aux carry", auxCarryFlag, 1'b1);
		alu(`PMTR_OP_DECADJ, 8'h00, 8'h10, 8'h16);
		alu(`PMTR_OP_SUB, 8'h60, 8'h50, 8'hF0);
		check("borrow", carryFlag, 1'b0);
		alu(`PMTR_OP_SBC, 8'h01, 8'h05, 8'h03);
		check("no borrow", carryFlag, 1'b1);
		alu(`PMTR_OP_RRC, 8'h00, 8'h02, 8'h81);
		check("rrc carry", carryFlag, 1'b0);
		alu(`PMTR_OP_RLC, 8'h00, 8'h80, 8'h00);
		check("rlc carry", carryFlag, 1'b1);
		alu(`PMTR_OP_SIZ, 8'h00, 8'hFF, 8'h00);
		check("skip set", skipNext, 1'b1);
		alu(`PMTR_OP_SDZ, 8'h00, 8'h05, 8'h04);
		check("skip clear", skipNext, 1'b0);
		alu(`PMTR_OP_AND, 8'h3C, 8'hF0, 8'h30);
		alu(`PMTR_OP_OR, 8'h0C, 8'hF0, 8'hFC);
		alu(`PMTR_OP_XOR, 8'h3C, 8'hF0, 8'hCC);
		alu(`PMTR_OP_CPL, 8'h00, 8'hA5, 8'h5A);
		alu(`PMTR_OP_RL, 8'h00, 8'h81, 8'h03);
		alu(`PMTR_OP_RR, 8'h00, 8'h81, 8'hC0);
		alu(`PMTR_OP_DEC, 8'h00, 8'h00, 8'hFF);
		alu(`PMTR_OP_INC, 8'h00, 8'hFF, 8'h00);
		check("zero", zeroFlag, 1'b1);
		$display("alu test done");
	endtask
	task automatic t_table;
		reg [15:0] w;
		w = 16'hA50F ^ 16'h2222;
		issue(`PMTR_OP_TRDC, 8'h40, 8'h00, 8'h02, 8);
		check("low byte", dataWrData, w[7:0]);
		check("table dest", dataWrAddr, 8'h40);
		check("high byte", tableHighByte, w[15:8]);
		dut.progMem[11'h706] = 16'h001A;
		issue(`PMTR_OP_TRDL, 8'h41, 8'h00, 8'h06, 8);
		check("last page dest", dataWrAddr, 8'h41);
		check("last page low", dataWrData, 8'h1A);
		check("last page high", tableHighByte, 8'h00);
		$display("table test done");
	endtask
	initial begin
		rst = 1'b1;
		instValid = 1'b0;
		debugMode = 1'b0;
		instOp = `PMTR_OP_NOP;
		instOperand = 8'h00;
		instDest = 8'h00;
		tablePointer = 8'h00;
		err_total = 0;
		checks_done = 0;
		do_reset;
		t_prog;
		do_reset;
		t_alu;
		t_table;
		test_done;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total = err_total + 1;
		test_done;
	end
endmodule // pmtr_core_bench
